// *** logic/rgef_event_flags.v ***
// event flag, mask and interrupt logic with classic wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "rgef_map.vh"

module rgef_event_flags (
    input  wire        i_clock,
    input  wire        i_rst_b,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [9:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    input  wire        i_thermal_shutdown_status,
    input  wire        i_power_good_status,
    input  wire        i_overvoltage_status,
    input  wire        i_overcurrent_status,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    output reg         o_irq
);

    // ****************************************
    // bus handshake states
    // ****************************************
    localparam [1:0] ST_IDLE     = 2'b01;
    localparam [1:0] ST_ANSWER   = 2'b10;
    localparam       ST_IDLE_BIT = 0;

    // ****************************************
    // state
    // ****************************************
    reg  [3:0]  event_mask;
    reg  [3:0]  event_flags;
    reg  [3:0]  pending;
    reg  [3:0]  irq_mask;
    reg  [3:0]  status_prev;
    reg         primed;
    reg  [1:0]  bus_state;

    reg  [3:0]  next_mask;
    reg  [3:0]  next_flags;
    reg  [3:0]  next_pending;
    reg  [3:0]  next_irq_mask;
    reg  [3:0]  next_status_prev;
    reg         next_primed;
    reg  [1:0]  next_state;
    reg  [31:0] read_value;
    reg         next_ack;
    reg  [31:0] next_dat;
    reg         next_irq;

    wire [3:0]  status_now;
    wire [3:0]  hit;
    wire [3:0]  masked_hit;
    wire        request;
    wire        access;
    wire        rd_access;
    wire        wr_lane0;
    wire        sel_mask;
    wire        sel_flags;
    wire        sel_pending;
    wire        sel_irq_mask;
    wire        rd_flags;
    wire        wr_mask;
    wire        wr_pending;
    wire        wr_irq_mask;

    // ****************************************
    // helper functions
    // ****************************************
    // zero extension of a four bit field
    function [31:0] rgef_pad;
        input [3:0] v;
        begin
            rgef_pad = {28'h0000000, v};
        end
    endfunction

    // rising transition between two samples
    function rgef_rise;
        input en;
        input prev;
        input cur;
        begin
            rgef_rise = en & ~prev & cur;
        end
    endfunction

    // falling transition between two samples
    function rgef_fall;
        input en;
        input prev;
        input cur;
        begin
            rgef_fall = en & prev & ~cur;
        end
    endfunction

    // full address compare
    function rgef_match;
        input [9:0] adr;
        input [9:0] target;
        begin
            rgef_match = (adr == target);
        end
    endfunction

    // clear selected bits, new sets win
    function [3:0] rgef_set_clear;
        input [3:0] cur;
        input [3:0] clr;
        input [3:0] add;
        begin
            rgef_set_clear = (cur & ~clr) | add;
        end
    endfunction

    // ****************************************
    // status capture
    // ****************************************
    assign status_now[`RGEF_BIT_TH] = i_thermal_shutdown_status;
    assign status_now[`RGEF_BIT_PG] = i_power_good_status;
    assign status_now[`RGEF_BIT_OV] = i_overvoltage_status;
    assign status_now[`RGEF_BIT_OC] = i_overcurrent_status;

    // ****************************************
    // edge detection
    // ****************************************
    assign hit[`RGEF_BIT_TH] = rgef_rise(primed, status_prev[`RGEF_BIT_TH],
                                         status_now[`RGEF_BIT_TH]);
    assign hit[`RGEF_BIT_PG] = rgef_fall(primed, status_prev[`RGEF_BIT_PG],
                                         status_now[`RGEF_BIT_PG]);
    assign hit[`RGEF_BIT_OV] = rgef_rise(primed, status_prev[`RGEF_BIT_OV],
                                         status_now[`RGEF_BIT_OV]);
    assign hit[`RGEF_BIT_OC] = rgef_rise(primed, status_prev[`RGEF_BIT_OC],
                                         status_now[`RGEF_BIT_OC]);
    assign masked_hit = hit & ~event_mask;

    // ****************************************
    // bus handshake
    // ****************************************
    assign request = i_wb_cyc & i_wb_stb;
    assign access  = bus_state[ST_IDLE_BIT] & request;

    always @* begin
        case (bus_state)
            ST_IDLE: begin
                if (request) begin
                    next_state = ST_ANSWER;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // bus decode
    // ****************************************
    assign sel_mask     = rgef_match(i_wb_adr, `RGEF_ADDR_MASK);
    assign sel_flags    = rgef_match(i_wb_adr, `RGEF_ADDR_FLAGS);
    assign sel_pending  = rgef_match(i_wb_adr, `RGEF_ADDR_PENDING);
    assign sel_irq_mask = rgef_match(i_wb_adr, `RGEF_ADDR_IRQ_MASK);
    assign rd_access    = access & ~i_wb_we;
    assign wr_lane0     = access & i_wb_we & i_wb_sel[0];
    assign rd_flags     = rd_access & sel_flags;
    assign wr_mask      = wr_lane0 & sel_mask;
    assign wr_pending   = wr_lane0 & sel_pending;
    assign wr_irq_mask  = wr_lane0 & sel_irq_mask;

    // ****************************************
    // next register values
    // ****************************************
    always @* begin
        if (wr_mask) begin
            next_mask = i_wb_dat[3:0];
        end else begin
            next_mask = event_mask;
        end
    end

    always @* begin
        if (wr_irq_mask) begin
            next_irq_mask = i_wb_dat[3:0];
        end else begin
            next_irq_mask = irq_mask;
        end
    end

    // read clears, new edge wins
    always @* begin
        if (rd_flags) begin
            next_flags = rgef_set_clear(event_flags, 4'hF, hit);
        end else begin
            next_flags = rgef_set_clear(event_flags, 4'h0, hit);
        end
    end

    // write one clears, new event wins
    always @* begin
        if (wr_pending) begin
            next_pending = rgef_set_clear(pending, i_wb_dat[3:0], masked_hit);
        end else begin
            next_pending = rgef_set_clear(pending, 4'h0, masked_hit);
        end
    end

    always @* begin
        next_status_prev = status_now;
        next_primed      = 1'b1;
    end

    // ****************************************
    // read back
    // ****************************************
    always @* begin
        case (i_wb_adr)
            `RGEF_ADDR_MASK: begin
                read_value = rgef_pad(event_mask);
            end
            `RGEF_ADDR_FLAGS: begin
                read_value = rgef_pad(event_flags);
            end
            `RGEF_ADDR_PENDING: begin
                read_value = rgef_pad(pending);
            end
            `RGEF_ADDR_IRQ_MASK: begin
                read_value = rgef_pad(irq_mask);
            end
            default: begin
                read_value = 32'h00000000;
            end
        endcase
    end

    // ****************************************
    // output values
    // ****************************************
    always @* begin
        next_ack = access;
        if (rd_access) begin
            next_dat = read_value;
        end else begin
            next_dat = 32'h00000000;
        end
    end

    always @* begin
        next_irq = |(next_pending & ~irq_mask);
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            event_mask <= `RGEF_RST_MASK;
        end else begin
            event_mask <= next_mask;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            event_flags <= `RGEF_RST_FLAGS;
        end else begin
            event_flags <= next_flags;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            pending <= `RGEF_RST_PENDING;
        end else begin
            pending <= next_pending;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            irq_mask <= `RGEF_RST_IRQ_MASK;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            status_prev <= `RGEF_RST_STATUS;
        end else begin
            status_prev <= next_status_prev;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            primed <= 1'b0;
        end else begin
            primed <= next_primed;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            bus_state <= ST_IDLE;
        end else begin
            bus_state <= next_state;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= next_ack;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_dat <= next_dat;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end

endmodule // rgef_event_flags
`default_nettype wire

// *** logic/rgef_map.vh ***
// register map and constants of the regulator event flag block
// Overview of operation
// - The mask register at 0x06 holds four read/write mask bits: thermal at 3, power-good at 2, overvoltage at 1, overcurrent at 0; a one masks the source.
// - The power-good mask bit sits at position 2, where a one masks and a zero unmasks the power-good event.
// - After reset the mask register reads 0x00, all sources unmasked, with the upper four bits reserved and reading zero.
// - The power-good flag at bit 2 of the status register at 0x07 sets when the power-good status falls from 1 to 0, and on no other change.
// - The overvoltage flag at bit 1 sets when the overvoltage status rises from 0 to 1, and on no other change.
// - The overcurrent flag at bit 0 sets when the overcurrent status rises from 0 to 1, and on no other change.
// - The thermal flag at bit 3 sets when the thermal shutdown status rises from 0 to 1, and on no other change.
`ifndef RGEF_MAP_VH
`define RGEF_MAP_VH

// ****************************************
// register byte addresses (index times 4)
// ****************************************
`define RGEF_IDX_MASK      8'h06
`define RGEF_IDX_FLAGS     8'h07
`define RGEF_IDX_PENDING   8'h08
`define RGEF_IDX_IRQ_MASK  8'h09
`define RGEF_ADDR_MASK     10'h018
`define RGEF_ADDR_FLAGS    10'h01C
`define RGEF_ADDR_PENDING  10'h020
`define RGEF_ADDR_IRQ_MASK 10'h024

// ****************************************
// field positions and reset values
// ****************************************
`define RGEF_BIT_OC        0
`define RGEF_BIT_OV        1
`define RGEF_BIT_PG        2
`define RGEF_BIT_TH        3
`define RGEF_RST_MASK      4'h0
`define RGEF_RST_FLAGS     4'h0
`define RGEF_RST_IRQ_MASK  4'h0
`define RGEF_RST_PENDING   4'h0
`define RGEF_RST_STATUS    4'h0

`endif

// *** tb/rgef_monitor.sv ***
// assertion checker of the event flag block
`timescale 1ns/1ps
`default_nettype none
module rgef_monitor (input wire logic i_clock, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
    i_thermal_shutdown_status, i_power_good_status, i_overvoltage_status, i_overcurrent_status,
    input wire logic [9:0] i_wb_adr, input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat, o_wb_dat);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    wire [3:0] s = {i_thermal_shutdown_status, i_power_good_status, i_overvoltage_status,
        i_overcurrent_status};
    wire t = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire f = t & ~i_wb_we & i_wb_adr == 10'h01C;
    wire m = t & ~i_wb_we & i_wb_adr == 10'h018;
    wire w = t & i_wb_we & i_wb_sel[0] & i_wb_adr == 10'h018;
    property p_ack; t |=> o_wb_ack ##1 !o_wb_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_rsv; m |=> o_wb_dat[31:4] == 28'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("rsv");
    property p_msk; w ##3 m |=> o_wb_dat[3:0] == $past(i_wb_dat[3:0], 4); endproperty
    a_msk: assert property (p_msk) else $error("msk");
    property p_clr; f && $stable(s) ##1 $stable(s)[*3] ##0 f |=> o_wb_dat == 32'h0; endproperty
    a_clr: assert property (p_clr) else $error("clr");
    property p_th; $rose(s[3]) && $past(i_rst_b) ##1 f |=> o_wb_dat[3]; endproperty
    a_th: assert property (p_th) else $error("th");
    property p_pg; $fell(s[2]) && $past(i_rst_b) ##1 f |=> o_wb_dat[2]; endproperty
    a_pg: assert property (p_pg) else $error("pg");
    property p_ov; $rose(s[1]) && $past(i_rst_b) ##1 f |=> o_wb_dat[1]; endproperty
    a_ov: assert property (p_ov) else $error("ov");
    property p_oc; $rose(s[0]) && $past(i_rst_b) ##1 f |=> o_wb_dat[0]; endproperty
    a_oc: assert property (p_oc) else $error("oc");
    c_th: cover property ($rose(s[3]) ##1 f);
    c_msk: cover property (w ##3 m);
    c_clr: cover property (f ##3 f);
endmodule // rgef_monitor
bind rgef_event_flags rgef_monitor i_mon (.*);
`default_nettype wire

// *** tb/rgef_host.sv ***
// host model issuing classic wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module rgef_host (input wire logic i_clock, i_ack, input wire logic [31:0] i_dat,
    output var logic o_cs, o_we, output var logic [9:0] o_adr,
    output var logic [3:0] o_sel, output var logic [31:0] o_dat);
    initial {o_cs, o_we, o_adr, o_sel, o_dat} = 48'h0;
    task acc(input logic [46:0] r, output logic [31:0] q); // data returned with the acknowledge of the cycle
        {o_we, o_adr, o_sel, o_dat} <= r;
        o_cs <= 1'b1;
        do @(posedge i_clock); while (!i_ack);
        q = i_dat;
        o_cs <= 1'b0;
        @(posedge i_clock);
    endtask
endmodule // rgef_host
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench of the event flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clock = 0, i_rst_b = 0, i_wb_cyc, i_wb_we, o_wb_ack, o_irq, run = 0;
    logic [9:0] i_wb_adr;
    logic [3:0] i_wb_sel, st = 4'h0, ps, ef, pd, mk, im, xv;
    wire [3:0] ev = i_rst_b ? (st ^ ps) & (st ^ 4'h4) : 4'h0;
    logic [31:0] i_wb_dat, o_wb_dat, q;
    int failures = 0, num_checks = 0;
    wire rd = i_wb_cyc & ~o_wb_ack & ~i_wb_we;
    wire wr = i_wb_cyc & ~o_wb_ack & i_wb_we & i_wb_sel[0];
    rgef_event_flags i_dut (.*, .i_wb_stb(i_wb_cyc), .i_thermal_shutdown_status(st[3]),
        .i_power_good_status(st[2]), .i_overvoltage_status(st[1]), .i_overcurrent_status(st[0]));
    rgef_host i_host (.i_clock, .i_ack(o_wb_ack), .i_dat(o_wb_dat), .o_cs(i_wb_cyc),
        .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
    function automatic logic [3:0] exp_rd(input logic [9:0] a);
        return a == 10'h018 ? mk : a == 10'h01C ? ef : a == 10'h020 ? pd :
            a == 10'h024 ? im : 4'h0;
    endfunction
    always @(posedge i_clock) begin
        ps <= st;
        if (run && $urandom % 3 == 0) st <= 4'($urandom);
        if (rd) xv <= exp_rd(i_wb_adr);
        ef <= (rd && i_wb_adr == 10'h01C ? 4'h0 : ef) | ev;
        pd <= (wr && i_wb_adr == 10'h020 ? pd & ~i_wb_dat[3:0] : pd) | ev & ~mk;
        if (wr && i_wb_adr == 10'h018) mk <= i_wb_dat[3:0];
        if (wr && i_wb_adr == 10'h024) im <= i_wb_dat[3:0];
        if (!i_rst_b) {ef, pd, mk, im} <= 16'h0;
    end
    task chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_irq(input logic g, e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t irq got %h exp %h", $time, g, e);
        end
    endtask
    task op(input logic [46:0] r);
        i_host.acc(r, q);
        if (!r[46]) chk(q, {28'h0, xv});
        chk_irq(o_irq, |(pd & ~im));
    endtask
    task close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial forever #50 i_clock = ~i_clock;
    initial begin
        #400_000;
        failures++;
        close_out;
    end
    initial begin
        void'($urandom(78696));
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clock);
        for (int a = 0; a < 6; a++) op({1'b0, 10'h018 + 10'(4 * a), 36'h0});
        op({1'b1, 10'h018, 4'h1, 32'hA});
        op({1'b0, 10'h018, 36'h0});
        $display("reset and mask test done");
        run <= 1'b1;
        repeat (600) op({1'($urandom), 10'h018 + 10'(4 * ($urandom % 5)), 4'($urandom),
            32'($urandom)});
        $display("random test done");
        close_out;
    end
endmodule // tb_top
`default_nettype wire
